/* rtl/add_and_shift_exec_unit.sv */
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "exec_unit_map.svh"

module add_and_shift_exec_unit
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [11:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);
	import exec_unit_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic is_file_addr(input logic [11:0] a);
		return a[`FILE_SEL_HI:`FILE_SEL_LO] == `FILE_SEL;
	endfunction

	function automatic instr_s decode(input logic [13:0] w);
		instr_s d;
		d.kind = OP_NONE;
		d.with_carry = 1'b0;
		d.dest = w[`F_DEST];
		d.ptr_sel = w[`F_PSEL];
		d.faddr = w[6:0];
		d.lit = w[7:0];
		if (w[13:7] == `OPC_PTR_ADD)
			d.kind = OP_PTRADD;
		else if (w[13:8] == `OPC_AND_LIT)
			d.kind = OP_ANDLIT;
		else if (w[13:8] == `OPC_ADD_LIT)
			d.kind = OP_ADDLIT;
		else if (w[13:8] == `OPC_AND_F)
			d.kind = OP_ANDF;
		else if (w[13:8] == `OPC_ADD_F)
			d.kind = OP_ADDF;
		else if (w[13:8] == `OPC_ADDC_F)
		begin
			d.kind = OP_ADDF;
			d.with_carry = 1'b1;
		end
		else if (w[13:8] == `OPC_ASR_F)
			d.kind = OP_ARITH_SHIFT_RIGHT_FILE;
		return d;
	endfunction

	function automatic alu_s run_alu(input instr_s i, input logic [7:0] a, input logic [7:0] f,
		input logic cy);
		alu_s r;
		logic [7:0] b;
		logic       cin;
		logic [8:0] s;
		logic [4:0] h;
		b = (i.kind == OP_ADDLIT) ? i.lit : f;
		cin = i.with_carry & cy;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r = '0;
		r.c = s[8];
		r.dig_c = h[4];
		unique case (i.kind)
			OP_ANDLIT:
			begin
				r.res = a & i.lit;
				r.set_z = 1'b1;
				r.to_acc = 1'b1;
			end
			OP_ADDLIT:
			begin
				r.res = s[7:0];
				{r.set_c, r.set_dig_c, r.set_z, r.to_acc} = 4'hF;
			end
			OP_ANDF:
			begin
				r.res = a & f;
				r.set_z = 1'b1;
			end
			OP_ADDF:
			begin
				r.res = s[7:0];
				{r.set_c, r.set_dig_c, r.set_z} = 3'h7;
			end
			OP_ARITH_SHIFT_RIGHT_FILE:
			begin
				r.res = {f[7], f[7:1]};
				r.c = f[0];
				{r.set_c, r.set_z} = 2'h3;
			end
			OP_NONE, OP_PTRADD:
				r.res = 8'h00;
		endcase
		if (i.kind inside {OP_ANDF, OP_ADDF, OP_ARITH_SHIFT_RIGHT_FILE})
		begin
			r.to_file = i.dest;
			r.to_acc = ~i.dest;
		end
		r.z = (r.res == 8'h00);
		return r;
	endfunction

	bus_state_e  st_reg;
	bus_state_e  st_next;
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic [11:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic [13:0] instr_reg;
	logic [7:0]  acc_reg;
	logic        c_reg;
	logic        dig_c_reg;
	logic        z_reg;
	logic [15:0] ptr_reg [2];
	logic [1:0]  cycles_reg;
	logic [1:0]  cnt_reg;
	logic [7:0]  mem [128];

	wire        do_write = (st_reg == ST_IDLE) && !awready_reg && !wready_reg;
	wire        hit_instr = waddr_reg == `OFS_INSTR;
	wire        hit_acc = waddr_reg == `OFS_ACC;
	wire        hit_stat = waddr_reg == `OFS_STATUS;
	wire        hit_p0 = waddr_reg == `OFS_PTR0;
	wire        hit_p1 = waddr_reg == `OFS_PTR1;
	wire        hit_file = is_file_addr(waddr_reg);
	wire        w_mapped = hit_instr | hit_acc | hit_stat | hit_p0 | hit_p1 | hit_file
		| (waddr_reg == `OFS_CYCLES);
	wire [31:0] wmerge = merge(32'h0000_0000, wdata_reg, wstrb_reg);
	wire        exec_go = do_write && hit_instr;

	wire instr_s     dec = decode(wmerge[13:0]);
	wire             ind = dec.faddr[6:1] == `IND_HI_ADDR;
	wire [15:0]      ind_ptr = ptr_reg[dec.faddr[0]];
	wire [6:0]       eff_addr = ind ? ind_ptr[6:0] : dec.faddr;
	wire             file_op = dec.kind inside {OP_ANDF, OP_ADDF, OP_ARITH_SHIFT_RIGHT_FILE};
	wire alu_s       alu = run_alu(dec, acc_reg, mem[eff_addr], c_reg);
	wire             ind_extra = file_op && ind && ind_ptr[`PTR_MSB];
	wire             pc_mod = alu.to_file && !ind && dec.faddr == `PC_LO_ADDR;
	wire [1:0]       extra = {1'b0, ind_extra} + {1'b0, pc_mod};
	wire [15:0]      ptr_sum = ptr_reg[dec.ptr_sel] + {{10{dec.lit[5]}}, dec.lit[5:0]};

	wire             mem_we = (do_write && hit_file && wstrb_reg[0])
		|| (exec_go && alu.to_file);
	wire [6:0]       mem_wa = exec_go ? eff_addr : waddr_reg[`FILE_IDX_HI:`FILE_IDX_LO];
	wire [7:0]       mem_wd = exec_go ? alu.res : wdata_reg[7:0];

	wire [31:0] acc_merge = merge({24'h0, acc_reg}, wdata_reg, wstrb_reg);
	wire [7:0]  acc_next = (exec_go && alu.to_acc) ? alu.res
		: (do_write && hit_acc) ? acc_merge[7:0] : acc_reg;
	wire        stat_wr = do_write && hit_stat && wstrb_reg[0];
	wire        c_next = (exec_go && alu.set_c) ? alu.c
		: stat_wr ? wdata_reg[`ST_C] : c_reg;
	wire        dig_c_next = (exec_go && alu.set_dig_c) ? alu.dig_c
		: stat_wr ? wdata_reg[`ST_DIG_C] : dig_c_reg;
	wire        z_next = (exec_go && alu.set_z) ? alu.z
		: stat_wr ? wdata_reg[`ST_Z] : z_reg;

	wire        busy = st_reg != ST_IDLE;
	wire        r_file = is_file_addr(araddr);
	wire [31:0] stat_word = {23'h0, busy, 5'h0, z_reg, dig_c_reg, c_reg};
	wire [31:0] rd_word = (araddr == `OFS_INSTR) ? {18'h0, instr_reg}
		: (araddr == `OFS_ACC) ? {24'h0, acc_reg}
		: (araddr == `OFS_STATUS) ? stat_word
		: (araddr == `OFS_PTR0) ? {16'h0, ptr_reg[0]}
		: (araddr == `OFS_PTR1) ? {16'h0, ptr_reg[1]}
		: (araddr == `OFS_CYCLES) ? {30'h0, cycles_reg}
		: r_file ? {24'h0, mem[araddr[`FILE_IDX_HI:`FILE_IDX_LO]]} : 32'h0000_0000;
	wire        r_mapped = r_file || araddr == `OFS_INSTR || araddr == `OFS_ACC
		|| araddr == `OFS_STATUS || araddr == `OFS_PTR0 || araddr == `OFS_PTR1
		|| araddr == `OFS_CYCLES;

	// The write answer waits for the whole instruction, so the bus sees its true length
	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			ST_IDLE:
				if (do_write)
					st_next = (exec_go && extra != 2'h0) ? ST_STALL : ST_RESP;
			ST_STALL:
				if (cnt_reg == `CYC_BASE)
					st_next = ST_RESP;
			ST_RESP:
				if (bready)
					st_next = ST_IDLE;
			default:
				st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg <= ST_IDLE;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end
		else
		begin
			st_reg <= st_next;
			if (awvalid && awready_reg)
				awready_reg <= 1'b0;
			else if (st_reg == ST_RESP && bready)
				awready_reg <= 1'b1;
			if (wvalid && wready_reg)
				wready_reg <= 1'b0;
			else if (st_reg == ST_RESP && bready)
				wready_reg <= 1'b1;
			bvalid_reg <= st_next == ST_RESP;
			if (do_write)
				bresp_reg <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			waddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end
		else
		begin
			if (awvalid && awready_reg)
				waddr_reg <= awaddr;
			if (wvalid && wready_reg)
			begin
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			instr_reg <= `INSTR_RST;
			acc_reg <= `ACC_RST;
			{c_reg, dig_c_reg, z_reg} <= 3'h0;
			cycles_reg <= `CYC_BASE;
			cnt_reg <= 2'h0;
		end
		else
		begin
			acc_reg <= acc_next;
			{c_reg, dig_c_reg, z_reg} <= {c_next, dig_c_next, z_next};
			if (exec_go)
			begin
				instr_reg <= wmerge[13:0];
				cycles_reg <= `CYC_BASE + extra;
				cnt_reg <= extra;
			end
			else if (st_reg == ST_STALL)
				cnt_reg <= cnt_reg - `CYC_BASE;
		end
	end

	// Pointer sum is 16 bits wide on purpose: the carry out is dropped so it wraps
	generate
		for (genvar n = 0; n < 2; n++)
		begin : g_ptr
			wire bus_hit = do_write && (n == 0 ? hit_p0 : hit_p1);
			wire [31:0] ptr_merge = merge({16'h0, ptr_reg[n]}, wdata_reg, wstrb_reg);
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					ptr_reg[n] <= `PTR_RST;
				else if (exec_go && dec.kind == OP_PTRADD && dec.ptr_sel == n[0])
					ptr_reg[n] <= ptr_sum;
				else if (bus_hit)
					ptr_reg[n] <= ptr_merge[15:0];
			end
		end
	endgenerate

	// File storage has no reset; software must initialise what it reads
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `RESP_OKAY;
		end
		else if (arvalid && arready_reg)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= r_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (rvalid_reg && rready)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

endmodule // add_and_shift_exec_unit

/* rtl/exec_unit_map.svh */
// Functional notes
// - PC change costs second cycle as no-op
// - Indirect access adds cycle when pointer MSB set
// - Pointer add sign-extends 6-bit literal, flags untouched
// - Pointer sum wraps modulo 16 bits
// - Literal AND into accumulator, zero only
// - Literal add into accumulator, all flags
// - File add, destination bit selects target
// - File AND, destination bit, zero only
// - Arithmetic right shift keeps MSb, LSb to carry
// - Add with carry, all flags, destination
// - Pointer add decoded from 1100010 prefix
`ifndef EXEC_UNIT_MAP_SVH
`define EXEC_UNIT_MAP_SVH

`define OFS_INSTR   12'h000
`define OFS_ACC     12'h004
`define OFS_STATUS  12'h008
`define OFS_PTR0    12'h00C
`define OFS_PTR1    12'h010
`define OFS_CYCLES  12'h014
`define FILE_SEL    3'h1
`define FILE_SEL_HI 11
`define FILE_SEL_LO 9
`define FILE_IDX_HI 8
`define FILE_IDX_LO 2

`define OPC_PTR_ADD 7'h62
`define OPC_AND_LIT 6'h39
`define OPC_ADD_LIT 6'h3E
`define OPC_ADD_F   6'h07
`define OPC_AND_F   6'h05
`define OPC_ASR_F   6'h37
`define OPC_ADDC_F  6'h3D
`define F_DEST      7
`define F_PSEL      6
`define IND_HI_ADDR 6'h00
`define PC_LO_ADDR  7'h02
`define PTR_MSB     15

`define ST_C        0
`define ST_DIG_C    1
`define ST_Z        2
`define ST_BUSY     8

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define ACC_RST     8'h00
`define PTR_RST     16'h0000
`define INSTR_RST   14'h0000
`define CYC_BASE    2'h1

`endif

/* rtl/exec_unit_pkg.sv */
package exec_unit_pkg;

	typedef enum logic [6:0] {
		OP_NONE   = 7'b0000001,
		OP_PTRADD = 7'b0000010,
		OP_ANDLIT = 7'b0000100,
		OP_ADDLIT = 7'b0001000,
		OP_ANDF   = 7'b0010000,
		OP_ADDF   = 7'b0100000,
		OP_ARITH_SHIFT_RIGHT_FILE   = 7'b1000000
	} op_kind_e;

	typedef struct packed {
		op_kind_e    kind;
		logic        with_carry;
		logic        dest;
		logic        ptr_sel;
		logic [6:0]  faddr;
		logic [7:0]  lit;
	} instr_s;

	typedef struct packed {
		logic [7:0]  res;
		logic        c;
		logic        dig_c;
		logic        z;
		logic        set_c;
		logic        set_dig_c;
		logic        set_z;
		logic        to_acc;
		logic        to_file;
	} alu_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_STALL = 3'b010,
		ST_RESP  = 3'b100
	} bus_state_e;

endpackage

/* verif/add_and_shift_exec_unit_props.sv */
`timescale 1ns/10ps
`include "exec_unit_map.svh"
module exec_unit_props
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [11:0] awaddr,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [31:0] wdata,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire wr_take = awvalid && awready && wvalid && wready;
	property p_rd_lat;
		arvalid && arready |=> rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	property p_rd_end;
		rvalid && rready |=> !rvalid && arready;
	endproperty
	a_rd_end: assert property (p_rd_end) else $error("read not closed");
	// A literal add never touches the program counter, so no second cycle
	property p_wr_lit;
		wr_take && awaddr == `OFS_INSTR && wdata[13:8] == `OPC_ADD_LIT |=> !bvalid ##1 bvalid;
	endproperty
	a_wr_lit: assert property (p_wr_lit) else $error("one cycle op timing");
	property p_wr_lat;
		wr_take |-> ##[2:4] bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_end;
		bvalid && bready |=> !bvalid && awready && wready;
	endproperty
	a_b_end: assert property (p_b_end) else $error("write not closed");
	property p_busy;
		bvalid |-> !awready && !wready;
	endproperty
	a_busy: assert property (p_busy) else $error("second write accepted");
endmodule // exec_unit_props

bind add_and_shift_exec_unit exec_unit_props u_props
(
	.clk, .arst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
	.bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata
);

/* verif/add_and_shift_exec_unit_test.sv */
`timescale 1ns/10ps
`include "exec_unit_map.svh"
module add_and_shift_exec_unit_test;
	localparam logic [5:0] opt [1:6] = '{`OPC_AND_LIT, `OPC_ADD_LIT, `OPC_ADD_F,
		`OPC_AND_F, `OPC_ASR_F, `OPC_ADDC_F};
	logic        clk = 1'h0;
	logic        arst_n = 1'h0;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [31:0] lf = 32'hB6EA;
	logic [31:0] rdata, rd, r;
	logic [1:0]  bresp, rresp, rs, br;
	logic        awready, wready, bvalid, arready, rvalid, c, dig_c, z;
	logic [7:0]  acc, fm [128];
	logic [15:0] ptr [2];
	logic [13:0] op;
	logic [6:0]  fe, fa;
	int          bad_count = 0;
	int          total_checks = 0;
	int          cyc;
	always #20 clk = ~clk;
	add_and_shift_exec_unit u_dut
	(
		.clk, .arst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.rvalid, .rready, .rdata, .rresp
	);
	function automatic logic [31:0] rnd();
		repeat (32) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Samples at the edge itself, before that edge's updates land
	task automatic wait_hi(input int w);
		int i;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if ((w == 0 ? awready & wready : w == 1 ? bvalid : w == 2 ? arready : rvalid) === 1'h1)
				break;
		end
		if (i == 50)
		begin
			bad_count++;
			test_done();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ao, wo;
		int   i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		ao = 1'h1;
		wo = 1'h1;
		// Each channel lets go at the edge that takes it, whatever the other does
		for (i = 0; i < 50 && (ao || wo); i++)
		begin
			@(posedge clk);
			if (ao && awready === 1'h1)
			begin
				ao = 1'h0;
				awvalid <= 1'h0;
			end
			if (wo && wready === 1'h1)
			begin
				wo = 1'h0;
				wvalid <= 1'h0;
			end
		end
		if (ao || wo)
		begin
			bad_count++;
			test_done();
		end
		// A late bready lets the response sit and be held
		repeat (lf[1] ? 3 : 0) @(posedge clk);
		bready <= 1'h1;
		wait_hi(1);
		br = bresp;
		bready <= 1'h0;
	endtask
	task automatic rdr(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		wait_hi(2);
		arvalid <= 1'h0;
		repeat (lf[2] ? 2 : 0) @(posedge clk);
		rready <= 1'h1;
		wait_hi(3);
		rd = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask
	task automatic exec();
		logic [8:0] s;
		logic [7:0] b, res;
		logic       ind, pm, ci, fo;
		ind = op[6:1] == 6'h00;
		pm = ind & ptr[op[0]][15];
		fe = ind ? ptr[op[0]][6:0] : op[6:0];
		fo = op[13:8] inside {`OPC_ADD_F, `OPC_AND_F, `OPC_ASR_F, `OPC_ADDC_F};
		b = fo ? fm[fe] : op[7:0];
		ci = (op[13:8] == `OPC_ADDC_F) & c;
		s = acc + b + ci;
		res = acc & b;
		cyc = 1 + (fo & pm) + (fo & op[7] & !ind & fe == 7'h02);
		if (op[13:7] == `OPC_PTR_ADD)
			ptr[op[6]] += {{10{op[5]}}, op[5:0]};
		else if (fo || op[13:8] inside {`OPC_AND_LIT, `OPC_ADD_LIT})
		begin
			if (op[13:8] == `OPC_ASR_F)
			begin
				res = {b[7], b[7:1]};
				c = b[0];
			end
			else if (op[13:8] inside {`OPC_ADD_LIT, `OPC_ADD_F, `OPC_ADDC_F})
			begin
				res = s[7:0];
				c = s[8];
				dig_c = acc[3:0] + b[3:0] + ci > 15;
			end
			z = res == 8'h00;
			if (fo & op[7])
				fm[fe] = res;
			else
				acc = res;
		end
	endtask
	task automatic cmp_all();
		logic [31:0] e [6];
		e = '{{18'h0, op}, {24'h0, acc}, {29'h0, z, dig_c, c}, {16'h0, ptr[0]},
			{16'h0, ptr[1]}, 32'(cyc)};
		for (int k = 0; k < 6; k++)
		begin
			rdr(12'(4 * k));
			chk(rd, e[k], $sformatf("reg %0d", k));
			chk({30'h0, rs}, {30'h0, `RESP_OKAY}, "read response");
		end
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		arst_n <= 1'h1;
		{acc, c, dig_c, z, ptr[0], ptr[1], op, cyc} = '0;
		cyc = 1;
		cmp_all();
		for (int i = 0; i < 128; i++)
		begin
			r = rnd();
			fm[i] = r[7:0];
			wr(12'(512 + 4 * i), {24'h0, fm[i]});
		end
		wr(12'h100, r);
		chk({30'h0, br}, {30'h0, `RESP_SLVERR}, "unmapped write");
		rdr(12'h100);
		chk({30'h0, rs}, {30'h0, `RESP_SLVERR}, "unmapped read");
		chk(rd, 32'h0, "unmapped data");
		for (int n = 0; n < 300; n++)
		begin
			r = rnd();
			acc = r[7:0];
			{z, dig_c, c} = r[10:8];
			ptr[r[11]] = {r[12], r[13] ? 8'hFF : 8'h00, r[30:24]};
			wr(`OFS_ACC, {24'h0, acc});
			wr(`OFS_STATUS, {29'h0, z, dig_c, c});
			wr(r[11] ? `OFS_PTR1 : `OFS_PTR0, {16'h0, ptr[r[11]]});
			r = rnd();
			fa = r[3] ? {5'h0, r[5:4]} : r[14:8];
			if (r[18:16] == 3'h0)
				op = {`OPC_PTR_ADD, r[6:0]};
			else if (r[18:16] == 3'h7)
				op = {2'h0, r[31:20]};
			else
				op = {opt[r[18:16]], r[18:16] < 3 ? r[31:24] : {r[7], fa}};
			wr(`OFS_INSTR, {18'h0, op});
			chk({30'h0, br}, 32'h0, "instr response");
			exec();
			cmp_all();
			rdr(12'(512 + 4 * fe));
			chk({24'h0, rd[7:0]}, {24'h0, fm[fe]}, "file");
		end
		test_done();
	end
endmodule // add_and_shift_exec_unit_test
